// File: logic/dbc_pkg.sv
package dbc_pkg;
  // =====================================================
  // Geometry
  // =====================================================
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;
  localparam int COL_W = 3;
  localparam int ROW_MEM_W = 2;
  localparam int DQ_W = 8;
  localparam int MEM_AW = BA_W + ROW_MEM_W + COL_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // =====================================================
  // Burst lengths
  // =====================================================
  localparam logic [2:0] LAST_BEAT_BL8 = 3'h7;
  localparam logic [2:0] LAST_BEAT_BC4 = 3'h3;

  // =====================================================
  // Timing counts
  // =====================================================
  localparam int CNT_W = 10;
  localparam logic [3:0] TRP_CYC = 4'h4;
  localparam logic [CNT_W-1:0] ZQ_INIT_CYC = 10'h200;
  localparam logic [CNT_W-1:0] ZQ_OPER_CYC = 10'h100;
  localparam logic [CNT_W-1:0] ZQ_SHORT_CYC = 10'h040;

  // =====================================================
  // Impedance codes
  // =====================================================
  localparam int ZQ_CODE_W = 6;
  localparam logic [ZQ_CODE_W-1:0] ZQ_CODE_RST = 6'h20;
  localparam logic [ZQ_CODE_W-1:0] ZQ_CODE_MAX = 6'h3F;
  localparam logic [ZQ_CODE_W-1:0] ZQ_CODE_MIN = 6'h00;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_LOAD} dbc_cal_state_t;
endpackage

// File: logic/dbc_mem_if.sv
interface dbc_mem_if;
  import dbc_pkg::*;
  logic we;
  logic [MEM_AW-1:0] addr;
  logic [DQ_W-1:0] wdata;
  logic [DQ_W-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// File: logic/dbc_mem.sv
module dbc_mem
  import dbc_pkg::*;
(
  input wire logic clk_in,
  dbc_mem_if.mem mem_io
);
  // =====================================================
  // Array with registered read port
  // =====================================================
  logic [DQ_W-1:0] ram_q [MEM_DEPTH];
  logic [DQ_W-1:0] rdata_q;

  always_ff @(posedge clk_in) begin
    if (mem_io.we) begin
      ram_q[mem_io.addr] <= mem_io.wdata;
    end
    rdata_q <= ram_q[mem_io.addr];
  end

  assign mem_io.rdata = rdata_q;
endmodule

// File: logic/dbc_cmd.sv
module dbc_cmd
  import dbc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ck_link_in,
  input wire logic cke_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [BA_W-1:0] ba_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic dm_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe_b_out,
  input wire logic zq_cmp_in,
  input wire logic otf_en_in,
  input wire logic bc4_fixed_in,
  input wire logic burst_ilv_in,
  output logic [ZQ_CODE_W-1:0] ron_code_out,
  output logic [ZQ_CODE_W-1:0] odt_code_out,
  output logic cal_busy_out,
  output logic [NUM_BANKS-1:0] bank_open_out,
  output logic illegal_cmd_out
);
  // =====================================================
  // Link-side reset and configuration synchronisers
  // =====================================================
  logic lrst_s1_q, lrst_s2_q;
  logic [2:0] cfg_s1_q, cfg_s2_q;

  always_ff @(posedge ck_link_in) begin
    lrst_s1_q <= rst_b_in;
    lrst_s2_q <= lrst_s1_q;
    cfg_s1_q <= {otf_en_in, bc4_fixed_in, burst_ilv_in};
    cfg_s2_q <= cfg_s1_q;
  end

  wire lrst_b = lrst_s2_q;
  wire otf_en = cfg_s2_q[2];
  wire bc4_fixed = cfg_s2_q[1];
  wire burst_ilv = cfg_s2_q[0];

  // =====================================================
  // Command decode on the link clock
  // =====================================================
  logic cke_prev_q;
  logic [NUM_BANKS-1:0] open_q, ap_pend_q;
  logic [3:0] pre_cnt_q [NUM_BANKS];
  logic [ADDR_W-1:0] row_q [NUM_BANKS];
  logic burst_act_q, burst_wr_q, burst_bl8_q, burst_ap_q;
  logic [BA_W-1:0] burst_ba_q;
  logic [ROW_MEM_W-1:0] burst_row_q;
  logic [COL_W-1:0] burst_col_q;
  logic [2:0] beat_q;

  wire cmd_sel = cke_prev_q & cke_in & ~cs_b_in;
  wire is_act = cmd_sel & ~ras_b_in & cas_b_in & we_b_in;
  wire is_rd = cmd_sel & ras_b_in & ~cas_b_in & we_b_in;
  wire is_wr = cmd_sel & ras_b_in & ~cas_b_in & ~we_b_in;
  wire is_pre = cmd_sel & ~ras_b_in & cas_b_in & ~we_b_in;
  wire is_zq = cmd_sel & ras_b_in & cas_b_in & ~we_b_in;
  wire a10 = addr_in[A10_POS];
  wire a12 = addr_in[A12_POS];

  // A bank with a pending auto precharge takes no further column access.
  wire acc_ok = open_q[ba_in] & ~ap_pend_q[ba_in] & ~burst_act_q;
  wire act_ok = ~open_q[ba_in] & (pre_cnt_q[ba_in] == 4'h0);
  wire acc_go = (is_rd | is_wr) & acc_ok;
  wire act_go = is_act & act_ok;
  wire illegal = ((is_rd | is_wr) & ~acc_ok) | (is_act & ~act_ok);
  wire new_bl8 = otf_en ? a12 : ~bc4_fixed;
  wire last_beat = beat_q == (burst_bl8_q ? LAST_BEAT_BL8 : LAST_BEAT_BC4);
  wire burst_end = burst_act_q & last_beat;

  always_ff @(posedge ck_link_in) begin
    if (!lrst_b) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= cke_in;
    end
  end

  // =====================================================
  // Per-bank open, row and precharge timing
  // =====================================================
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire sel_b = ba_in == BA_W'(b);
      wire pre_hit = is_pre & (a10 | sel_b);
      wire ap_hit = burst_end & burst_ap_q & (burst_ba_q == BA_W'(b));
      // Idle banks ignore it, but a running period restarts from the latest one.
      wire pre_load = (pre_hit & (open_q[b] | (pre_cnt_q[b] != 4'h0))) | ap_hit;
      wire pre_close = pre_hit | ap_hit;

      always_ff @(posedge ck_link_in) begin
        if (!lrst_b) begin
          open_q[b] <= 1'b0;
          ap_pend_q[b] <= 1'b0;
          pre_cnt_q[b] <= 4'h0;
          row_q[b] <= '0;
        end else begin
          if (act_go && sel_b) begin
            open_q[b] <= 1'b1;
            row_q[b] <= addr_in;
          end else if (pre_close) begin
            open_q[b] <= 1'b0;
          end
          if (acc_go && sel_b && a10) begin
            ap_pend_q[b] <= 1'b1;
          end else if (pre_close) begin
            ap_pend_q[b] <= 1'b0;
          end
          if (pre_load) begin
            pre_cnt_q[b] <= TRP_CYC;
          end else if (pre_cnt_q[b] != 4'h0) begin
            pre_cnt_q[b] <= pre_cnt_q[b] - 4'h1;
          end
        end
      end
    end
  endgenerate

  // =====================================================
  // Burst engine
  // =====================================================
  always_ff @(posedge ck_link_in) begin
    if (!lrst_b) begin
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bl8_q <= 1'b0;
      burst_ap_q <= 1'b0;
      burst_ba_q <= '0;
      burst_row_q <= '0;
      burst_col_q <= '0;
      beat_q <= 3'h0;
    end else if (acc_go) begin
      burst_act_q <= 1'b1;
      burst_wr_q <= is_wr;
      burst_bl8_q <= new_bl8;
      burst_ap_q <= a10;
      burst_ba_q <= ba_in;
      burst_row_q <= row_q[ba_in][ROW_MEM_W-1:0];
      burst_col_q <= addr_in[COL_W-1:0];
      beat_q <= 3'h0;
    end else if (burst_end) begin
      burst_act_q <= 1'b0;
      beat_q <= 3'h0;
    end else if (burst_act_q) begin
      beat_q <= beat_q + 3'h1;
    end
  end

  // Sequential order wraps within a group of four; interleaved order XORs the beat index.
  wire [COL_W-1:0] col_seq = {burst_col_q[2] ^ beat_q[2], burst_col_q[1:0] + beat_q[1:0]};
  wire [COL_W-1:0] col_ilv = burst_col_q ^ beat_q;
  wire [COL_W-1:0] beat_col = burst_ilv ? col_ilv : col_seq;

  // =====================================================
  // Data path to the array
  // =====================================================
  dbc_mem_if mem_bus ();

  assign mem_bus.addr = {burst_ba_q, burst_row_q, beat_col};
  assign mem_bus.wdata = dq_in;
  assign mem_bus.we = burst_act_q & burst_wr_q & ~dm_in;

  dbc_mem u_mem (
    .clk_in(ck_link_in),
    .mem_io(mem_bus.mem)
  );

  logic rd_vld_q;

  always_ff @(posedge ck_link_in) begin
    if (!lrst_b) begin
      rd_vld_q <= 1'b0;
    end else begin
      rd_vld_q <= burst_act_q & ~burst_wr_q;
    end
  end

  assign dq_out = mem_bus.rdata;
  assign dq_oe_b_out = ~rd_vld_q;

  // =====================================================
  // Events toward the reference domain
  // =====================================================
  // The length flag settles a link cycle before the toggle moves, so the reference side never pairs
  // a new event with a stale length.
  logic zq_req_q, zq_tgl_q, zq_long_q, err_tgl_q;

  always_ff @(posedge ck_link_in) begin
    if (!lrst_b) begin
      zq_req_q <= 1'b0;
      zq_tgl_q <= 1'b0;
      zq_long_q <= 1'b0;
      err_tgl_q <= 1'b0;
    end else begin
      zq_req_q <= is_zq;
      if (is_zq) begin
        zq_long_q <= a10;
      end
      if (zq_req_q) begin
        zq_tgl_q <= ~zq_tgl_q;
      end
      if (illegal) begin
        err_tgl_q <= ~err_tgl_q;
      end
    end
  end

  // =====================================================
  // Reference-domain synchronisers
  // =====================================================
  logic [2:0] ev_s1_q, ev_s2_q;
  logic zq_s3_q, err_s3_q, err_pulse_q;
  logic [NUM_BANKS-1:0] bank_s1_q, bank_s2_q;

  always_ff @(posedge ref_clk_in) begin
    ev_s1_q <= {zq_tgl_q, zq_long_q, err_tgl_q};
    ev_s2_q <= ev_s1_q;
    bank_s1_q <= open_q;
    bank_s2_q <= bank_s1_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      zq_s3_q <= 1'b0;
      err_s3_q <= 1'b0;
      err_pulse_q <= 1'b0;
    end else begin
      zq_s3_q <= ev_s2_q[2];
      err_s3_q <= ev_s2_q[0];
      err_pulse_q <= ev_s2_q[0] ^ err_s3_q;
    end
  end

  wire zq_evt = ev_s2_q[2] ^ zq_s3_q;
  wire zq_long = ev_s2_q[1];

  assign illegal_cmd_out = err_pulse_q;
  assign bank_open_out = bank_s2_q;

  // =====================================================
  // Calibration engine
  // =====================================================
  logic cmp_s1_q, cmp_s2_q;
  dbc_cal_state_t cal_st_q;
  logic [CNT_W-1:0] cal_cnt_q;
  logic [ZQ_CODE_W-1:0] work_q, ron_q, odt_q;
  logic init_done_q;

  always_ff @(posedge ref_clk_in) begin
    cmp_s1_q <= zq_cmp_in;
    cmp_s2_q <= cmp_s1_q;
  end

  // The first long run after reset gets the larger initialisation window.
  wire [CNT_W-1:0] long_cyc = init_done_q ? ZQ_OPER_CYC : ZQ_INIT_CYC;
  wire [CNT_W-1:0] run_cyc = zq_long ? long_cyc : ZQ_SHORT_CYC;
  wire step_up = cmp_s2_q & (work_q != ZQ_CODE_MAX);
  wire step_dn = ~cmp_s2_q & (work_q != ZQ_CODE_MIN);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cal_st_q <= CAL_IDLE;
      cal_cnt_q <= '0;
      work_q <= ZQ_CODE_RST;
      ron_q <= ZQ_CODE_RST;
      odt_q <= ZQ_CODE_RST;
      init_done_q <= 1'b0;
    end else begin
      unique case (cal_st_q)
        CAL_IDLE: begin
          if (zq_evt) begin
            cal_st_q <= CAL_RUN;
            cal_cnt_q <= run_cyc;
            if (zq_long) begin
              work_q <= ZQ_CODE_RST;
              init_done_q <= 1'b1;
            end
          end
        end
        CAL_RUN: begin
          if (step_up) begin
            work_q <= work_q + 6'h01;
          end else if (step_dn) begin
            work_q <= work_q - 6'h01;
          end
          cal_cnt_q <= cal_cnt_q - 10'h001;
          if (cal_cnt_q == 10'h001) begin
            cal_st_q <= CAL_LOAD;
          end
        end
        CAL_LOAD: begin
          ron_q <= work_q;
          odt_q <= work_q;
          cal_st_q <= CAL_IDLE;
        end
      endcase
    end
  end

  assign ron_code_out = ron_q;
  assign odt_code_out = odt_q;
  assign cal_busy_out = cal_st_q != CAL_IDLE;
endmodule

// File: tb/dbc_cmd_sva.sv
module dbc_cmd_sva
  import dbc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ck_link_in,
  input wire logic cke_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic dq_oe_b_out,
  input wire logic [ZQ_CODE_W-1:0] ron_code_out,
  input wire logic [ZQ_CODE_W-1:0] odt_code_out,
  input wire logic cal_busy_out,
  input wire logic [NUM_BANKS-1:0] bank_open_out,
  input wire logic illegal_cmd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================
  // Command decode
  // =====================================================
  logic cke_prev_q;
  logic [CNT_W:0] busy_cnt_q;
  wire cmd_ok = cke_prev_q & cke_in & ~cs_b_in;
  wire is_rd = cmd_ok & ras_b_in & ~cas_b_in & we_b_in;
  wire is_zq = cmd_ok & ras_b_in & cas_b_in & ~we_b_in;
  wire pre_all = cmd_ok & ~ras_b_in & cas_b_in & ~we_b_in & addr_in[A10_POS];
  always_ff @(posedge ck_link_in) cke_prev_q <= cke_in;
  always_ff @(posedge ref_clk_in) busy_cnt_q <= (rst_b_in && cal_busy_out) ? busy_cnt_q + 1'b1 : '0;
  // =====================================================
  // Properties
  // =====================================================
  property p_rd_lat;
    @(posedge ck_link_in) disable iff (!rst_b_in) $fell(dq_oe_b_out) |-> $past(is_rd, 3) || $past(is_rd, 2);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data without read");
  property p_burst;
    @(posedge ck_link_in) disable iff (!rst_b_in) $fell(dq_oe_b_out) |-> !dq_oe_b_out [*4];
  endproperty
  a_burst: assert property (p_burst) else $error("read burst cut short");
  property p_zq_go;
    @(posedge ck_link_in) disable iff (!rst_b_in) is_zq |-> ##[0:4] cal_busy_out;
  endproperty
  a_zq_go: assert property (p_zq_go) else $error("calibration not started");
  property p_pre_all;
    @(posedge ck_link_in) disable iff (!rst_b_in) pre_all |-> ##[1:6] (bank_open_out == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks left open");
  property p_ill;
    @(posedge ref_clk_in) disable iff (!rst_b_in) illegal_cmd_out |=> !illegal_cmd_out;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal flag too long");
  property p_cal_len;
    @(posedge ref_clk_in) disable iff (!rst_b_in) $fell(cal_busy_out) |-> busy_cnt_q inside {[64:66], [256:258], [512:514]};
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  property p_cal_end;
    @(posedge ref_clk_in) disable iff (!rst_b_in) $rose(cal_busy_out) |-> ##[64:530] !cal_busy_out;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration never ends");
  property p_code;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      $changed(ron_code_out) || $changed(odt_code_out) |-> cal_busy_out || $past(cal_busy_out);
  endproperty
  a_code: assert property (p_code) else $error("code moved while idle");
  c_read: cover property (@(posedge ck_link_in) $fell(dq_oe_b_out));
  c_pre_all: cover property (@(posedge ck_link_in) pre_all);
  c_cal: cover property (@(posedge ref_clk_in) $fell(cal_busy_out));
  c_ill: cover property (@(posedge ref_clk_in) illegal_cmd_out);
endmodule

bind dbc_cmd dbc_cmd_sva u_sva (
  .ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in),
  .ck_link_in(ck_link_in),
  .cke_in(cke_in),
  .cs_b_in(cs_b_in),
  .ras_b_in(ras_b_in),
  .cas_b_in(cas_b_in),
  .we_b_in(we_b_in),
  .addr_in(addr_in),
  .dq_oe_b_out(dq_oe_b_out),
  .ron_code_out(ron_code_out),
  .odt_code_out(odt_code_out),
  .cal_busy_out(cal_busy_out),
  .bank_open_out(bank_open_out),
  .illegal_cmd_out(illegal_cmd_out)
);

// File: tb/dbc_ctrl_model.sv
module dbc_ctrl_model
  import dbc_pkg::*;
(
  input wire logic ck_link_in,
  output logic cke_out,
  output logic cs_b_out,
  output logic ras_b_out,
  output logic cas_b_out,
  output logic we_b_out,
  output logic [BA_W-1:0] ba_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DQ_W-1:0] dq_out,
  output logic dm_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cke_out = 1'b1;
    {cs_b_out, ras_b_out, cas_b_out, we_b_out} = 4'hF;
    ba_out = 3'h0;
    addr_out = 14'h0000;
    dq_out = 8'h00;
    dm_out = 1'b1;
  end
  // Called 1 ns after a link edge; released bank and address pins show the inverse and command pins go high, so stale values never pass as valid.
  task automatic cmd(input logic [2:0] rcw, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
    {cs_b_out, ras_b_out, cas_b_out, we_b_out} = {1'b0, rcw};
    ba_out = ba;
    addr_out = a;
    @(posedge ck_link_in);
    #1;
    {cs_b_out, ras_b_out, cas_b_out, we_b_out} = 4'hF;
    ba_out = ~ba;
    addr_out = ~a;
  endtask
  task automatic wburst(input logic [63:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      dq_out = d[8*i +: 8];
      dm_out = m[i];
      @(posedge ck_link_in);
      #1;
    end
    dq_out = ~dq_out;
    dm_out = ~dm_out;
  endtask
endmodule

// File: tb/dbc_cmd_test.sv
module dbc_cmd_test
  import dbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, PRE = 3'h2, ZQ = 3'h6;
  logic ref_clk = 1'b0, ck_link = 1'b0, rst_b = 1'b0, zq_cmp = 1'b0;
  logic otf_en = 1'b1, bc4_fixed = 1'b0, burst_ilv = 1'b0;
  logic cke, cs_b, ras_b, cas_b, we_b, dm, dq_oe_b, cal_busy, illegal;
  logic [BA_W-1:0] ba, b;
  logic [ADDR_W-1:0] addr, rows [NUM_BANKS];
  logic [DQ_W-1:0] dq_wr, dq_rd, dq_wire;
  logic [ZQ_CODE_W-1:0] ron, odt;
  logic [NUM_BANKS-1:0] bank_open;
  logic [7:0] mem [MEM_DEPTH];
  int failures = 0, comparisons = 0, n_ill = 0, cnt;
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #7.5 ck_link = ~ck_link;
  end
  assign dq_wire = !dq_oe_b ? dq_rd : dq_wr;
  always @(posedge ref_clk) if (illegal === 1'b1) n_ill++;
  dbc_cmd uut (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .ck_link_in(ck_link), .cke_in(cke), .cs_b_in(cs_b),
    .ras_b_in(ras_b), .cas_b_in(cas_b), .we_b_in(we_b), .ba_in(ba), .addr_in(addr), .dq_in(dq_wire), .dm_in(dm),
    .dq_out(dq_rd), .dq_oe_b_out(dq_oe_b), .zq_cmp_in(zq_cmp), .otf_en_in(otf_en), .bc4_fixed_in(bc4_fixed),
    .burst_ilv_in(burst_ilv), .ron_code_out(ron), .odt_code_out(odt), .cal_busy_out(cal_busy),
    .bank_open_out(bank_open), .illegal_cmd_out(illegal));
  dbc_ctrl_model ctl (.ck_link_in(ck_link), .cke_out(cke), .cs_b_out(cs_b), .ras_b_out(ras_b), .cas_b_out(cas_b),
    .we_b_out(we_b), .ba_out(ba), .addr_out(addr), .dq_out(dq_wr), .dm_out(dm));
  task automatic chk_stat(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    chk_stat({8'h00, got}, {8'h00, exp});
  endtask
  function automatic int blen(input logic a12);
    return otf_en ? (a12 ? 8 : 4) : (bc4_fixed ? 4 : 8);
  endfunction
  function automatic logic [MEM_AW-1:0] loc(input logic [BA_W-1:0] bk, input logic [2:0] c, input logic [2:0] i);
    return {bk, rows[bk][1:0], burst_ilv ? c ^ i : {c[2] ^ i[2], c[1:0] + i[1:0]}};
  endfunction
  function automatic int cal_len(input int k);
    return k == 0 ? int'(ZQ_INIT_CYC) : k == 1 ? int'(ZQ_SHORT_CYC) : int'(ZQ_OPER_CYC);
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge ck_link);
    #1;
  endtask
  task automatic act(input logic [BA_W-1:0] bk);
    rows[bk] = 14'($urandom);
    ctl.cmd(ACT, bk, rows[bk]);
    idle(1);
  endtask
  task automatic wr_rd(input logic [BA_W-1:0] bk, input logic ap);
    logic [2:0] c;
    logic a12;
    logic [63:0] d;
    logic [7:0] m;
    int n;
    c = 3'($urandom);
    a12 = 1'($urandom);
    d = {$urandom, $urandom};
    m = 8'($urandom);
    n = blen(a12);
    ctl.cmd(WR, bk, {1'b0, a12, 2'h0, 7'h00, c});
    ctl.wburst(d, m, n);
    for (int i = 0; i < n; i++) if (!m[i]) mem[loc(bk, c, i[2:0])] = d[8*i +: 8];
    a12 = 1'($urandom);
    n = blen(a12);
    ctl.cmd(RD, bk, {1'b0, a12, 1'b0, ap, 7'h00, c});
    for (int i = 0; i < n; i++) begin
      @(posedge ck_link);
      #1;
      chk_stat(dq_oe_b, 1'b0);
      if (!$isunknown(mem[loc(bk, c, i[2:0])])) chk_data(dq_rd, mem[loc(bk, c, i[2:0])]);
    end
    idle(1);
    chk_stat(dq_oe_b, 1'b1);
  endtask
  task automatic results();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    void'($urandom(32'hA321));
    repeat (12) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    idle(3);
    chk_stat({ron, odt}, {2{ZQ_CODE_RST}});
    chk_stat({cal_busy, dq_oe_b, illegal, bank_open}, {3'b010, 8'h00});
    $display("Test reset done");
    for (int k = 0; k < 3; k++) begin
      zq_cmp = (k == 2);
      ctl.cmd(ZQ, 3'($urandom), {3'h0, k != 1, 10'h000});
      cnt = 0;
      while (cal_busy !== 1'b1 && cnt < 40) begin
        @(posedge ref_clk);
        #1;
        cnt++;
      end
      cnt = 0;
      while (cal_busy === 1'b1 && cnt < 700) begin
        @(posedge ref_clk);
        #1;
        cnt++;
      end
      chk_stat(cnt >= cal_len(k) - 1 && cnt <= cal_len(k) + 2, 1'b1);
      #1;
      chk_stat({ron, odt}, {2{zq_cmp ? ZQ_CODE_MAX : ZQ_CODE_MIN}});
      idle(1);
    end
    $display("Test calibration done");
    ctl.cmd(RD, 3'h3, 14'h0000);
    idle(1);
    act(3'h3);
    idle(1);
    ctl.cmd(ACT, 3'h3, 14'h0000);
    idle(6);
    chk_stat({n_ill[7:0], bank_open}, {8'h02, 8'h08});
    ctl.cmd(PRE, 3'h3, 14'h0000);
    idle(1);
    ctl.cmd(PRE, 3'h3, 14'h0000);
    idle(2);
    ctl.cmd(ACT, 3'h3, 14'h0000);
    idle(8);
    chk_stat({n_ill[7:0], bank_open}, {8'h03, 8'h00});
    $display("Test bank refusals done");
    for (int k = 0; k < 24; k++) begin
      {otf_en, bc4_fixed, burst_ilv} = 3'($urandom);
      b = 3'($urandom);
      idle(4);
      act(b);
      act(b + 3'h1);
      wr_rd(b, 1'b1);
      wr_rd(b + 3'h1, 1'b0);
      idle(6);
      chk_stat(bank_open, 8'h01 << (b + 3'h1));
      cnt = $urandom % 2;
      ctl.cmd(PRE, cnt ? 3'($urandom) : b + 3'h1, {3'h0, cnt[0], 10'h000});
      idle(8);
      chk_stat({n_ill[7:0], bank_open}, {8'h03, 8'h00});
    end
    $display("Test random bursts done");
    results();
  end
endmodule
